// >>> rtl/bfi_pkg.sv
// Purpose: constants shared by the bias fault interrupt logic
// Assumes: clk_sys at 200 MHz
// Notes: times kept in their own units, cycle counts derived from them
package bfi_pkg;

    localparam int CLK_MHZ = 200;

    // -------------------------------------------------------------
    // interrupt pulse timing
    // -------------------------------------------------------------
    localparam int PULSE_US = 10;
    localparam int WAIT_US = 480;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int WAIT_CYC = WAIT_US * CLK_MHZ;

    // -------------------------------------------------------------
    // default masks and delays (in microseconds)
    // -------------------------------------------------------------
    localparam int UV_MASK_US = 1000;
    localparam int HICCUP_US = 10000;
    localparam int RDY_DLY0_US = 0;
    localparam int RDY_DLY1_US = 100;
    localparam int RDY_DLY2_US = 1000;
    localparam int RDY_DLY3_US = 10000;

    // -------------------------------------------------------------
    // register fields
    // -------------------------------------------------------------
    localparam int FA_OVLO = 0;
    localparam int FA_SOFT_TSD = 2;
    localparam int FA_HARD_TSD = 3;
    localparam int FB_UV = 0;
    localparam int FB_OV = 1;
    localparam int FB_OC = 2;
    localparam int PC_DLY_LO = 3;
    localparam int PC_IRQ_DIS = 5;
    localparam int RE_AUX_EN = 0;
    localparam logic [7:0] PIN_CFG_RST = 8'h20;
    localparam logic [7:0] RAIL_EN_RST = 8'h03;

    // -------------------------------------------------------------
    // clock generator roles and address choices
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        BFI_ROLE_ALONE,
        BFI_ROLE_MASTER,
        BFI_ROLE_SLAVE
    } bfi_role_type;

endpackage

// >>> rtl/bfi_counter.sv
// Purpose: down counter that pulses done when a loaded count expires
// Assumes: load wins over counting
// Notes: used for mask, hiccup and ready delay timing
module bfi_counter (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic [31:0] count,
    // status
    output logic busy,
    output logic done
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_busy;
    logic next_done;

    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (load) begin
            next_cnt = count;
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt <= 32'h1) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_cnt = 32'h0;
            end else begin
                next_cnt = cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 32'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule

// >>> rtl/bfi_top.sv
// Purpose: fault flag latching, aux regulator control and ready/interrupt pin
// Assumes: comparator and event inputs are synchronous to clk_sys
// Notes: nrst is the supply-valid reset; int_reset is the internal reboot
//
// Operation
// - rail over-voltage sets fault_flags_b bit 1.
// - rail under-voltage sets fault_flags_b bit 0.
// - under-voltage detection masked for fixed interval from soft-start.
// - aux regulator enables on rail power-good, gated by rail_enable_reg bit 0.
// - aux target is 0.9 V plus 50 mV times six-bit code.
// - aux code reset value comes from factory configuration input.
// - aux power-good raises error only after aux soft-start done.
// - ready pin released only when bias blocks and interface ready.
// - pin_config_reg bits 4:3 select delay before ready rising edge.
// - pin_config_reg bit 5 resets to one and suppresses interrupt pulses.
// - any flag bit rising from zero raises an interrupt event.
// - interrupt drives pin low for 10 us then releases it.
// - after each pulse wait 480 us for a read, else repulse.
// - reading the causing flag register clears both flag registers.
// - internal reset sequence keeps registers and flags.
// - after reboot pulsing resumes with timing continued from trigger.
// - soft thermal shutdown stops main converter only, sets flags_a bit 2.
// - main converter held off for hiccup, restarts once cooled.
// - hard thermal shutdown runs internal reset, sets flags_a bit 3.
// - clock role fixed together with address selection.
// - alone disables shared clock, master drives it, slave follows it.
// - rail over-current sets fault_flags_b bit 2.
// - input over-voltage lockout sets fault_flags_a bit 0.
module bfi_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // fault and status events
    input wire logic rail_ov,
    input wire logic rail_uv,
    input wire logic rail_oc,
    input wire logic rail_pgood,
    input wire logic rail_ss_start,
    input wire logic input_ovlo,
    input wire logic soft_tsd,
    input wire logic hard_tsd,
    input wire logic temp_cool,
    input wire logic aux_pgood,
    input wire logic aux_ss_done,
    input wire logic bias_ready,
    input wire logic iface_ready,
    // register access from the serial interface
    input wire logic pin_cfg_we,
    input wire logic [7:0] pin_cfg_wdata,
    input wire logic rail_en_we,
    input wire logic [7:0] rail_en_wdata,
    input wire logic aux_code_we,
    input wire logic [5:0] aux_code_wdata,
    input wire logic rd_flags_a,
    input wire logic rd_flags_b,
    // factory configuration and address selection
    input wire logic [5:0] rom_aux_code,
    input wire logic rom_valid,
    input wire logic [1:0] addr_sel,
    input wire logic addr_valid,
    // shared clock pin
    input wire logic osc_clk,
    input wire logic shared_clk_in,
    output logic shared_clk_out,
    output logic shared_clk_oe,
    output logic ext_clk,
    // register views
    output logic [7:0] fault_flags_a,
    output logic [7:0] fault_flags_b,
    output logic [7:0] pin_config_reg,
    output logic [7:0] rail_enable_reg,
    output logic [5:0] aux_voltage_code_reg,
    // control outputs
    output logic aux_enable,
    output logic aux_error,
    output logic main_enable,
    output logic int_reset,
    output logic [1:0] clk_role,
    // open-drain ready/interrupt pin
    output logic bias_ready_irq_out,
    output logic bias_ready_irq_oe
);
    typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_WAIT} bfi_irq_type;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] us_to_cyc(input int us);
        us_to_cyc = (us * bfi_pkg::CLK_MHZ < 1) ? 32'h1 : 32'(us * bfi_pkg::CLK_MHZ);
    endfunction

    function automatic logic [31:0] rdy_delay(input logic [1:0] sel);
        case (sel)
            2'h0: rdy_delay = us_to_cyc(bfi_pkg::RDY_DLY0_US);
            2'h1: rdy_delay = us_to_cyc(bfi_pkg::RDY_DLY1_US);
            2'h2: rdy_delay = us_to_cyc(bfi_pkg::RDY_DLY2_US);
            default: rdy_delay = us_to_cyc(bfi_pkg::RDY_DLY3_US);
        endcase
    endfunction

    // -------------------------------------------------------------
    // register and flag state
    // -------------------------------------------------------------
    logic [7:0] next_fa, next_fb, next_pc, next_re;
    logic [5:0] next_code;
    logic [7:0] fa_set, fb_set;
    logic uv_armed, next_uv_armed, rom_done, next_rom_done;
    logic clr_flags;
    logic uv_done;

    always_comb begin
        fa_set = 8'h0;
        fb_set = 8'h0;
        fa_set[bfi_pkg::FA_OVLO] = input_ovlo;
        fa_set[bfi_pkg::FA_SOFT_TSD] = soft_tsd;
        fa_set[bfi_pkg::FA_HARD_TSD] = hard_tsd;
        fb_set[bfi_pkg::FB_OV] = rail_ov;
        fb_set[bfi_pkg::FB_UV] = rail_uv && uv_armed;
        fb_set[bfi_pkg::FB_OC] = rail_oc;
        // set wins over the read clear
        next_fa = (clr_flags ? 8'h0 : fault_flags_a) | fa_set;
        next_fb = (clr_flags ? 8'h0 : fault_flags_b) | fb_set;
        next_pc = pin_cfg_we ? pin_cfg_wdata : pin_config_reg;
        next_re = rail_en_we ? rail_en_wdata : rail_enable_reg;
        next_code = aux_voltage_code_reg;
        next_rom_done = rom_done;
        if (rom_valid && !rom_done) begin
            next_code = rom_aux_code;
            next_rom_done = 1'b1;
        end else if (aux_code_we) begin
            next_code = aux_code_wdata;
        end
        next_uv_armed = uv_armed;
        if (rail_ss_start) begin
            next_uv_armed = 1'b0;
        end else if (uv_done) begin
            next_uv_armed = 1'b1;
        end
    end

    // flags and registers survive int_reset; nrst loads their reset values, and an interrupt read also clears the flags
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fault_flags_a <= 8'h0;
            fault_flags_b <= 8'h0;
            pin_config_reg <= bfi_pkg::PIN_CFG_RST;
            rail_enable_reg <= bfi_pkg::RAIL_EN_RST;
            aux_voltage_code_reg <= 6'h0;
            rom_done <= 1'b0;
            uv_armed <= 1'b0;
        end else begin
            fault_flags_a <= next_fa;
            fault_flags_b <= next_fb;
            pin_config_reg <= next_pc;
            rail_enable_reg <= next_re;
            aux_voltage_code_reg <= next_code;
            rom_done <= next_rom_done;
            uv_armed <= next_uv_armed;
        end
    end

    bfi_counter u_uv_mask (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(rail_ss_start),
        .count(us_to_cyc(bfi_pkg::UV_MASK_US)),
        .busy(),
        .done(uv_done)
    );

    // -------------------------------------------------------------
    // interrupt sequencer
    // -------------------------------------------------------------
    bfi_irq_type irq_st, next_irq_st;
    logic [31:0] irq_cnt, next_irq_cnt;
    logic cause_a, cause_b, next_cause_a, next_cause_b;
    logic irq_event, irq_low, irq_read;

    always_comb begin
        irq_event = |(fa_set & ~fault_flags_a) || |(fb_set & ~fault_flags_b);
        irq_read = (rd_flags_a && cause_a) || (rd_flags_b && cause_b);
        clr_flags = (irq_st != IRQ_IDLE) && irq_read;
        next_irq_st = irq_st;
        next_irq_cnt = irq_cnt;
        next_cause_a = cause_a | |(fa_set & ~fault_flags_a);
        next_cause_b = cause_b | |(fb_set & ~fault_flags_b);
        case (irq_st)
            IRQ_IDLE: begin
                if (irq_event) begin
                    next_irq_st = IRQ_PULSE;
                    next_irq_cnt = 32'(bfi_pkg::PULSE_CYC);
                end
            end
            IRQ_PULSE: begin
                // a new event keeps the running sequence
                if (irq_cnt <= 32'h1) begin
                    next_irq_st = IRQ_WAIT;
                    next_irq_cnt = 32'(bfi_pkg::WAIT_CYC);
                end else begin
                    next_irq_cnt = irq_cnt - 32'h1;
                end
            end
            default: begin
                if (irq_cnt <= 32'h1) begin
                    next_irq_st = IRQ_PULSE;
                    next_irq_cnt = 32'(bfi_pkg::PULSE_CYC);
                end else begin
                    next_irq_cnt = irq_cnt - 32'h1;
                end
            end
        endcase
        if (clr_flags) begin
            next_irq_st = IRQ_IDLE;
            next_irq_cnt = 32'h0;
            next_cause_a = 1'b0;
            next_cause_b = 1'b0;
        end
    end

    // timing not reset by int_reset, so pulsing continues after reboot
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_st <= IRQ_IDLE;
            irq_cnt <= 32'h0;
            cause_a <= 1'b0;
            cause_b <= 1'b0;
        end else begin
            irq_st <= next_irq_st;
            irq_cnt <= next_irq_cnt;
            cause_a <= next_cause_a;
            cause_b <= next_cause_b;
        end
    end

    // -------------------------------------------------------------
    // ready delay, thermal and aux control
    // -------------------------------------------------------------
    logic rdy_int, rdy_q, rdy_ok, next_rdy_ok;
    logic rdy_done;
    logic hic_busy, hic_hold, next_hic_hold;
    logic next_main, next_aux_en, next_aux_err, next_int_reset, next_pin_low;

    always_comb begin
        rdy_int = bias_ready && iface_ready && !int_reset;
        next_rdy_ok = rdy_ok;
        if (!rdy_int) begin
            next_rdy_ok = 1'b0;
        end else if (rdy_done) begin
            next_rdy_ok = 1'b1;
        end
        irq_low = (irq_st == IRQ_PULSE) && !pin_config_reg[bfi_pkg::PC_IRQ_DIS];
        next_pin_low = !rdy_ok || irq_low;
        next_hic_hold = hic_hold;
        if (soft_tsd) begin
            next_hic_hold = 1'b1;
        end else if (!hic_busy && temp_cool) begin
            next_hic_hold = 1'b0;
        end
        next_main = rdy_ok && !next_hic_hold && !soft_tsd && !hard_tsd;
        next_int_reset = hard_tsd;
        next_aux_en = rail_pgood && rail_enable_reg[bfi_pkg::RE_AUX_EN];
        next_aux_err = next_aux_en && aux_ss_done && !aux_pgood;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdy_q <= 1'b0;
            rdy_ok <= 1'b0;
            hic_hold <= 1'b0;
            main_enable <= 1'b0;
            int_reset <= 1'b0;
            aux_enable <= 1'b0;
            aux_error <= 1'b0;
            bias_ready_irq_oe <= 1'b1;
        end else begin
            rdy_q <= rdy_int;
            rdy_ok <= next_rdy_ok;
            hic_hold <= next_hic_hold;
            main_enable <= next_main;
            int_reset <= next_int_reset;
            aux_enable <= next_aux_en;
            aux_error <= next_aux_err;
            bias_ready_irq_oe <= next_pin_low;
        end
    end

    assign bias_ready_irq_out = 1'b0;

    bfi_counter u_rdy_dly (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(rdy_int && !rdy_q),
        .count(rdy_delay(pin_config_reg[bfi_pkg::PC_DLY_LO +: 2])),
        .busy(),
        .done(rdy_done)
    );

    bfi_counter u_hiccup (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(soft_tsd && !hic_hold),
        .count(us_to_cyc(bfi_pkg::HICCUP_US)),
        .busy(hic_busy),
        .done()
    );

    // -------------------------------------------------------------
    // clock role
    // -------------------------------------------------------------
    logic [1:0] next_role;
    logic role_done, next_role_done;
    logic next_clk_out, next_clk_oe, next_ext;

    always_comb begin
        next_role = clk_role;
        next_role_done = role_done;
        if (addr_valid && !role_done) begin
            next_role_done = 1'b1;
            case (addr_sel)
                2'h0: next_role = bfi_pkg::BFI_ROLE_ALONE;
                2'h1: next_role = bfi_pkg::BFI_ROLE_MASTER;
                default: next_role = bfi_pkg::BFI_ROLE_SLAVE;
            endcase
        end
        next_clk_oe = role_done && (clk_role == bfi_pkg::BFI_ROLE_MASTER);
        next_clk_out = next_clk_oe && osc_clk;
        next_ext = (clk_role == bfi_pkg::BFI_ROLE_SLAVE) ? shared_clk_in : osc_clk;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clk_role <= 2'h0;
            role_done <= 1'b0;
            shared_clk_out <= 1'b0;
            shared_clk_oe <= 1'b0;
            ext_clk <= 1'b0;
        end else begin
            clk_role <= next_role;
            role_done <= next_role_done;
            shared_clk_out <= next_clk_out;
            shared_clk_oe <= next_clk_oe;
            ext_clk <= next_ext;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_ov_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
        rail_ov |=> fault_flags_b[1]) else $error("ov flag not set");
    a_oc_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
        rail_oc |=> fault_flags_b[2]) else $error("oc flag not set");
    a_uv_masked: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!uv_armed && rail_uv && !fault_flags_b[0] && !clr_flags) |=> !fault_flags_b[0])
        else $error("uv flag set while masked");
    a_aux_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
        !rail_enable_reg[0] |=> !aux_enable) else $error("aux on while disabled");
    a_irq_start: assert property (@(posedge clk_sys) disable iff (!nrst)
        (irq_st == IRQ_IDLE && irq_event && !clr_flags) |=> irq_st == IRQ_PULSE)
        else $error("event did not start pulse");
    a_pulse_width: assert property (@(posedge clk_sys) disable iff (!nrst)
        ($rose(irq_st == IRQ_PULSE) && !irq_read) |=> (irq_cnt == 32'(bfi_pkg::PULSE_CYC) - 1)
        || irq_st == IRQ_IDLE) else $error("pulse width wrong");
    a_read_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
        clr_flags |=> fault_flags_a == $past(fa_set) && fault_flags_b == $past(fb_set))
        else $error("flags not cleared");
    a_irq_suppr: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pin_config_reg[5] && rdy_ok) |=> !bias_ready_irq_oe) else $error("pulse while off");
    a_hard_tsd: assert property (@(posedge clk_sys) disable iff (!nrst)
        hard_tsd |=> int_reset && fault_flags_a[3]) else $error("hard tsd missed");
endmodule

// >>> bench/bfi_host_model.sv
// Purpose: host controller model that reads the flags after low pulses
// Assumes: pin level already resolved with its pull-up
// Notes: reads only while auto_rd is high
module bfi_host_model (
    // clock
    input wire logic clk_sys,
    // pin and control
    input wire logic pin_level,
    input wire logic auto_rd,
    // flag reads
    output logic rd_flags_a,
    output logic rd_flags_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_low = 1'b0;
    initial begin
        rd_flags_a = 1'b0;
        rd_flags_b = 1'b0;
    end
    // one read of both flag registers once a low pulse has ended
    always @(negedge clk_sys) begin
        rd_flags_a <= 1'b0;
        rd_flags_b <= 1'b0;
        if (pin_level === 1'b0) begin
            seen_low <= 1'b1;
        end else if (seen_low && auto_rd) begin
            seen_low <= 1'b0;
            rd_flags_a <= 1'b1;
            rd_flags_b <= 1'b1;
        end
    end
endmodule

// >>> bench/bias_fault_interrupt_logic_bench.sv
// Purpose: self-checking bench for the fault flag and interrupt pin logic
// Assumes: inputs driven at the falling clock edge
// Notes: pin resolved with a pull-up
module bias_fault_interrupt_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic osc_clk = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [3:0] lvl = 4'h0;
    logic [2:0] we = 3'b000;
    logic [7:0] wdata = 8'h00;
    logic rom_valid = 1'b0;
    logic addr_valid = 1'b0;
    logic auto_rd = 1'b0;
    logic rd_a, rd_b, oe, irq_out, pin_level;
    logic [7:0] flags_a, flags_b, pcfg, ren;
    logic [5:0] code;
    logic [1:0] role;
    logic aux_en, aux_err, main_en, int_rst, sco, scoe, ext;
    int err_total = 0;
    int num_checks = 0;
    int g, w;

    assign pin_level = (oe === 1'b1) ? irq_out : 1'b1;
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always #50 osc_clk = ~osc_clk;

    bfi_top i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .rail_ov(ev[0]), .rail_uv(ev[1]),
        .rail_oc(ev[2]), .rail_pgood(lvl[0]), .rail_ss_start(ev[6]),
        .input_ovlo(ev[3]), .soft_tsd(ev[4]), .hard_tsd(ev[5]), .temp_cool(lvl[2]),
        .aux_pgood(lvl[3]), .aux_ss_done(ev[7]), .bias_ready(lvl[1]),
        .iface_ready(lvl[1]), .pin_cfg_we(we[0]), .pin_cfg_wdata(wdata),
        .rail_en_we(we[1]), .rail_en_wdata(wdata), .aux_code_we(we[2]),
        .aux_code_wdata(wdata[5:0]), .rd_flags_a(rd_a), .rd_flags_b(rd_b),
        .rom_aux_code(6'h2a), .rom_valid(rom_valid), .addr_sel(2'h1),
        .addr_valid(addr_valid), .osc_clk(osc_clk), .shared_clk_in(1'b0),
        .shared_clk_out(sco), .shared_clk_oe(scoe), .ext_clk(ext),
        .fault_flags_a(flags_a), .fault_flags_b(flags_b), .pin_config_reg(pcfg),
        .rail_enable_reg(ren), .aux_voltage_code_reg(code), .aux_enable(aux_en),
        .aux_error(aux_err), .main_enable(main_en), .int_reset(int_rst),
        .clk_role(role), .bias_ready_irq_out(irq_out), .bias_ready_irq_oe(oe)
    );

    bfi_host_model i_host (
        .clk_sys(clk_sys), .pin_level(pin_level), .auto_rd(auto_rd),
        .rd_flags_a(rd_a), .rd_flags_b(rd_b)
    );

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi);
        num_checks++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic pulse_ev(input int i);
        cyc(1);
        ev[i] = 1'b1;
        cyc(1);
        ev[i] = 1'b0;
        cyc(1);
    endtask

    // sel 0 pin config, 1 rail enable, 2 aux code
    task automatic wr(input int sel, input logic [7:0] d);
        cyc(1);
        wdata = d;
        we = 3'b001 << sel;
        cyc(1);
        we = 3'b000;
        cyc(1);
    endtask

    // cycles until the pin is pulled low, then cycles it stays low
    task automatic meas(output int gap, output int wid);
        gap = 0;
        wid = 0;
        while (oe !== 1'b1 && gap < 100000) begin
            cyc(1);
            gap++;
        end
        while (oe === 1'b1 && wid < 100000) begin
            cyc(1);
            wid++;
        end
    endtask

    // number of sampled cycles with the pin pulled low
    task automatic lows(input int n, output int hits);
        hits = 0;
        repeat (n) begin
            cyc(1);
            if (oe !== 1'b0) hits++;
        end
    endtask

    initial begin
        #700000;
        err_total++;
        complete_run();
    end

    initial begin
        cyc(6);
        chk(oe, 1'b1);
        cyc(6);
        nrst = 1'b1;
        cyc(1);
        chk(pcfg, bfi_pkg::PIN_CFG_RST);
        chk(ren, bfi_pkg::RAIL_EN_RST);
        rom_valid = 1'b1;
        addr_valid = 1'b1;
        cyc(3);
        chk(code, 8'h2a);
        chk(role, bfi_pkg::BFI_ROLE_MASTER);
        chk(scoe, 1'b1);
        @(posedge osc_clk);
        cyc(2);
        chk({sco, ext}, 8'h03);
        @(negedge osc_clk);
        cyc(2);
        chk({sco, ext}, 8'h00);
        wr(2, 8'h15);
        chk(code, 8'h15);
        lvl = 4'b1101;
        cyc(3);
        chk(aux_en, 1'b1);
        wr(1, 8'h02);
        chk(aux_en, 1'b0);
        wr(1, 8'h03);
        lvl[3] = 1'b0;
        cyc(3);
        chk(aux_err, 1'b0);
        ev[7] = 1'b1;
        cyc(3);
        chk(aux_err, 1'b1);
        lvl[3] = 1'b1;
        lvl[1] = 1'b1;
        cyc(10);
        chk(oe, 1'b0);
        pulse_ev(0);
        chk(flags_b, 8'h02);
        lows(300, g);
        chk_rng(g, 0, 0);
        // restart with interrupts enabled
        lvl[1] = 1'b0;
        nrst = 1'b0;
        cyc(2);
        nrst = 1'b1;
        wr(0, 8'h00);
        lvl[1] = 1'b1;
        cyc(10);
        pulse_ev(6);
        pulse_ev(1);
        chk(flags_b, 8'h00);
        pulse_ev(2);
        chk(flags_b, 8'h04);
        meas(g, w);
        chk_rng(w, bfi_pkg::PULSE_CYC - 1, bfi_pkg::PULSE_CYC + 1);
        meas(g, w);
        chk_rng(g, bfi_pkg::WAIT_CYC - 2, bfi_pkg::WAIT_CYC + 2);
        pulse_ev(3);
        chk(flags_a, 8'h01);
        lows(500, g);
        chk_rng(g, 0, 0);
        auto_rd = 1'b1;
        cyc(4);
        chk(flags_a | flags_b, 8'h00);
        pulse_ev(4);
        chk(flags_a, 8'h04);
        chk({main_en, aux_en}, 8'h01);
        cyc(2100);
        chk(flags_a, 8'h00);
        lvl[2] = 1'b1;
        // reboot halfway through a pulse: the pulse keeps its original end
        pulse_ev(3);
        cyc(997);
        pulse_ev(5);
        cyc(50);
        chk(flags_a, 8'h09);
        meas(g, w);
        chk_rng(w, bfi_pkg::PULSE_CYC - 1052, bfi_pkg::PULSE_CYC - 1048);
        cyc(10);
        chk(flags_a, 8'h00);
        complete_run();
    end
endmodule
